// ### verilog/psda_pkg.sv
// Package with constants, encodings and the state record of the program space data access block.
`default_nettype none
package psda_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int PAGE_W = 8;
  localparam int EA_W = 16;
  localparam int PADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int MID_LSB = 8;
  localparam int TOP_LSB = 16;
  localparam int CFG_BIT = 7;
  localparam int VIS_EN_BIT = 2;
  localparam int VIS_LOW_W = 15;
  localparam int EA_BSEL_BIT = 0;
  localparam logic [EA_W-1:0] VIS_BASE = 16'h8000;

  // ----------------------------------------------------------------
  // Counts, reset values and lane masks
  // ----------------------------------------------------------------
  localparam logic [PADDR_W-1:0] PC_STEP = 24'h000002;
  localparam logic [PADDR_W-1:0] PC_RESET = 24'h000000;
  localparam logic [1:0] PEN_MOVE = 2'h1;
  localparam logic [1:0] PEN_OTHER = 2'h2;
  localparam logic [1:0] PEN_RPT_EDGE = 2'h2;
  localparam logic [1:0] PEN_RPT_MID = 2'h0;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_LO_BYTE = 3'h1;
  localparam logic [2:0] MASK_MID_BYTE = 3'h2;
  localparam logic [2:0] MASK_LO_WORD = 3'h3;
  localparam logic [2:0] MASK_TOP_BYTE = 3'h4;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_DATA_READ = 3'b000,
    OP_DATA_WRITE = 3'b001,
    OP_TABLE_READ_LOW = 3'b010,
    OP_TABLE_READ_HIGH = 3'b011,
    OP_TABLE_WRITE_LOW = 3'b100,
    OP_TABLE_WRITE_HIGH = 3'b101
  } psda_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_PENALTY = 2'b10,
    ST_TWRITE = 2'b11
  } psda_state_e;

  typedef struct packed {
    psda_state_e state;
    psda_op_e op;
    logic fetch;
    logic high_part;
    logic byte_mode;
    logic byte_sel;
    logic [1:0] pen;
    logic [PADDR_W-1:0] prog_addr;
    logic prog_rd;
    logic prog_wr;
    logic prog_cfg;
    logic [PADDR_W-1:0] prog_wdata;
    logic [2:0] prog_wmask;
    logic dspace_sel;
    logic dspace_we;
    logic [DATA_W-1:0] dspace_wdata;
    logic [DATA_W-1:0] data_rdata;
    logic done;
    logic [PADDR_W-1:0] pc;
  } psda_state_s;

endpackage
`default_nettype wire

// ### verilog/psda_steer_if.sv
// Interface carrying a fetched program word to the read lane steering logic and back.
`timescale 1ns/1ps
`default_nettype none
interface psda_steer_if;
  logic [psda_pkg::PADDR_W-1:0] word;
  logic high_part;
  logic byte_mode;
  logic byte_sel;
  logic [psda_pkg::DATA_W-1:0] data;

  modport requester (output word, output high_part, output byte_mode, output byte_sel,
    input data);
  modport steerer (input word, input high_part, input byte_mode, input byte_sel,
    output data);
endinterface
`default_nettype wire

// ### verilog/psda_lane_steer.sv
// Read lane steering from a 24-bit program word onto the 16-bit data path.
`timescale 1ns/1ps
`default_nettype none
module psda_lane_steer (
  // Word in, steered data out
  psda_steer_if.steerer sif
);

  // ----------------------------------------------------------------
  // Steering
  // ----------------------------------------------------------------
  always_comb begin
    sif.data = '0;
    if (sif.high_part) begin
      // The byte above the top byte does not exist and always reads as zero.
      if (!(sif.byte_mode && sif.byte_sel)) begin
        sif.data[psda_pkg::BYTE_W-1:0] = sif.word[psda_pkg::TOP_LSB +: psda_pkg::BYTE_W]; // [R10] [R11]
      end
    end else if (sif.byte_mode) begin
      if (sif.byte_sel) begin
        sif.data[psda_pkg::BYTE_W-1:0] = sif.word[psda_pkg::MID_LSB +: psda_pkg::BYTE_W]; // [R9]
      end else begin
        sif.data[psda_pkg::BYTE_W-1:0] = sif.word[psda_pkg::BYTE_W-1:0]; // [R9]
      end
    end else begin
      sif.data = sif.word[psda_pkg::DATA_W-1:0]; // [R8] [R14]
    end
  end

endmodule // psda_lane_steer
`default_nettype wire

// ### verilog/psda_top.sv
// Program space data access: table access and visibility window mapping onto program memory.
//
// How it works
// [R1] Table address is the table page register above the 16-bit effective address.
// [R2] Table page bit 7 selects configuration memory; clear selects user memory.
// [R3] Visibility address is the visibility page above effective address bits 14 to 0.
// [R4] Remapping happens only while core control bit 2 enables visibility.
// [R5] Visibility accesses always go to user memory; address bit 23 is zero.
// [R6] Program address bit 15 comes from visibility page bit 0, not address bit 15.
// [R7] The program counter advances by two per program word.
// [R8] Word table read low returns program bits 15 to 0 unchanged.
// [R9] Byte table read low returns the upper or lower byte by byte select.
// [R10] Word table read high returns the top byte with data bits 15 to 8 zero.
// [R11] Byte table read high returns the top byte, or zero for the phantom byte.
// [R12] Low table operations touch the low word; only high ones touch the top byte.
// [R13] The visibility window is data addresses 0x8000 and above.
// [R14] Visibility reads return only the low 16 bits of the program word.
// [R15] Outside repeat, visibility adds one cycle to moves, two to others.
// [R16] In repeat, edge iterations add two cycles; middle iterations add none.
// [R17] Visibility remapping is suspended while a table operation is in progress.
// [R18] Without remapping an access is an ordinary data access, no program fetch.
// [R19] A table write loads the holding buffer as one two-cycle word write.
`timescale 1ns/1ps
`default_nettype none
module psda_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Core request
  input wire logic req_valid,
  output logic req_ready,
  input wire psda_pkg::psda_op_e req_op,
  input wire logic byte_mode,
  input wire logic [psda_pkg::EA_W-1:0] effective_address,
  input wire logic [psda_pkg::DATA_W-1:0] write_data,
  input wire logic is_move,
  // Repeat loop status
  input wire logic rpt_active,
  input wire logic rpt_first,
  input wire logic rpt_last,
  input wire logic rpt_irq_exit,
  input wire logic rpt_irq_reentry,
  // Configuration
  input wire logic [psda_pkg::PAGE_W-1:0] table_page_reg,
  input wire logic [psda_pkg::PAGE_W-1:0] visibility_page_reg,
  input wire logic [psda_pkg::DATA_W-1:0] core_control_reg,
  // Core answer
  output logic done,
  output logic [psda_pkg::DATA_W-1:0] read_data,
  output logic table_busy,
  // Program counter
  input wire logic pc_advance,
  output logic [psda_pkg::PADDR_W-1:0] pc,
  // Program memory
  output logic prog_rd,
  output logic prog_wr,
  output logic prog_cfg,
  output logic [psda_pkg::PADDR_W-1:0] prog_addr,
  output logic [psda_pkg::PADDR_W-1:0] prog_wdata,
  output logic [2:0] prog_wmask,
  input wire logic [psda_pkg::PADDR_W-1:0] prog_rdata,
  // Data space
  output logic dspace_sel,
  output logic dspace_we,
  output logic [psda_pkg::EA_W-1:0] dspace_addr,
  output logic [psda_pkg::DATA_W-1:0] dspace_wdata,
  input wire logic [psda_pkg::DATA_W-1:0] dspace_rdata
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rsync;
  logic rst_n_sync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'h1};
    end
  end
  assign rst_n_sync = rsync[1];

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  psda_pkg::psda_state_s st;
  psda_pkg::psda_state_s next_st;
  psda_steer_if sif ();
  logic accept;
  logic is_table;
  logic is_twrite;
  logic vis_en;
  logic in_window;
  logic remap;
  logic rpt_edge;
  logic bsel;
  logic [1:0] penalty;
  logic [psda_pkg::EA_W-1:0] ea_q;

  assign accept = req_valid && req_ready;
  assign is_table = (req_op != psda_pkg::OP_DATA_READ) && (req_op != psda_pkg::OP_DATA_WRITE);
  assign is_twrite = (req_op == psda_pkg::OP_TABLE_WRITE_LOW) ||
    (req_op == psda_pkg::OP_TABLE_WRITE_HIGH);
  assign vis_en = core_control_reg[psda_pkg::VIS_EN_BIT]; // [R4]
  assign in_window = effective_address >= psda_pkg::VIS_BASE; // [R13]
  // A table operation in flight keeps the window closed.
  assign remap = (req_op == psda_pkg::OP_DATA_READ) && vis_en && in_window && !table_busy; // [R4] [R17] [R18]
  assign rpt_edge = rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reentry;
  assign bsel = effective_address[psda_pkg::EA_BSEL_BIT];

  always_comb begin
    if (!rpt_active) begin
      penalty = is_move ? psda_pkg::PEN_MOVE : psda_pkg::PEN_OTHER; // [R15]
    end else begin
      penalty = rpt_edge ? psda_pkg::PEN_RPT_EDGE : psda_pkg::PEN_RPT_MID; // [R16]
    end
  end

  assign sif.word = prog_rdata;
  assign sif.high_part = st.high_part;
  assign sif.byte_mode = st.byte_mode;
  assign sif.byte_sel = st.byte_sel;

  psda_lane_steer u_steer (
    .sif(sif.steerer)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.prog_rd = 1'h0;
    next_st.prog_wr = 1'h0;
    next_st.dspace_sel = 1'h0;
    next_st.done = 1'h0;
    if (pc_advance) begin
      next_st.pc = st.pc + psda_pkg::PC_STEP; // [R7]
    end
    case (st.state)
      psda_pkg::ST_IDLE: begin
        if (accept) begin
          next_st.op = req_op;
          next_st.byte_mode = byte_mode;
          next_st.byte_sel = bsel;
          next_st.high_part = (req_op == psda_pkg::OP_TABLE_READ_HIGH);
          next_st.pen = 2'h0;
          next_st.fetch = 1'h0;
          next_st.dspace_we = 1'h0;
          if (is_table) begin
            next_st.prog_addr = {table_page_reg, effective_address}; // [R1]
            next_st.prog_cfg = table_page_reg[psda_pkg::CFG_BIT]; // [R2]
          end
          if (is_twrite) begin
            next_st.state = psda_pkg::ST_TWRITE; // [R19]
            next_st.prog_wr = 1'h1;
            if (req_op == psda_pkg::OP_TABLE_WRITE_LOW) begin
              next_st.prog_wdata = {8'h00, byte_mode ? write_data[psda_pkg::BYTE_W-1:0] :
                write_data[psda_pkg::DATA_W-1:psda_pkg::BYTE_W],
                write_data[psda_pkg::BYTE_W-1:0]};
              if (!byte_mode) begin
                next_st.prog_wmask = psda_pkg::MASK_LO_WORD; // [R12]
              end else begin
                next_st.prog_wmask = bsel ? psda_pkg::MASK_MID_BYTE : psda_pkg::MASK_LO_BYTE; // [R12]
              end
            end else begin
              next_st.prog_wdata = {write_data[psda_pkg::BYTE_W-1:0], 16'h0000};
              // The phantom byte has no storage, so a byte write to it changes nothing.
              next_st.prog_wmask = (byte_mode && bsel) ? psda_pkg::MASK_NONE :
                psda_pkg::MASK_TOP_BYTE; // [R12]
            end
          end else if (is_table) begin
            next_st.state = psda_pkg::ST_ACCESS;
            next_st.prog_rd = 1'h1;
            next_st.fetch = 1'h1;
          end else if (remap) begin
            next_st.state = psda_pkg::ST_ACCESS;
            next_st.prog_rd = 1'h1;
            next_st.fetch = 1'h1;
            next_st.byte_mode = 1'h0; // [R14]
            next_st.prog_cfg = 1'h0; // [R5]
            next_st.prog_addr = {1'h0, visibility_page_reg,
              effective_address[psda_pkg::VIS_LOW_W-1:0]}; // [R3] [R5] [R6]
            next_st.pen = penalty; // [R15] [R16]
          end else begin
            next_st.state = psda_pkg::ST_ACCESS; // [R18]
            next_st.dspace_sel = 1'h1;
            next_st.dspace_we = (req_op == psda_pkg::OP_DATA_WRITE);
            next_st.dspace_wdata = write_data;
          end
        end
      end
      psda_pkg::ST_ACCESS: begin
        next_st.data_rdata = st.fetch ? sif.data : dspace_rdata;
        if (st.pen == 2'h0) begin
          next_st.done = 1'h1;
          next_st.state = psda_pkg::ST_IDLE;
        end else begin
          next_st.state = psda_pkg::ST_PENALTY;
        end
      end
      psda_pkg::ST_PENALTY: begin
        next_st.pen = st.pen - 2'h1;
        if (st.pen == 2'h1) begin
          next_st.done = 1'h1;
          next_st.state = psda_pkg::ST_IDLE;
        end
      end
      psda_pkg::ST_TWRITE: begin
        next_st.done = 1'h1; // [R19]
        next_st.state = psda_pkg::ST_IDLE;
      end
      default: begin
        next_st.state = psda_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st <= '0;
      ea_q <= '0;
    end else begin
      st <= next_st;
      if (accept) begin
        ea_q <= effective_address;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready = (st.state == psda_pkg::ST_IDLE);
  assign table_busy = (st.state != psda_pkg::ST_IDLE) && (st.op != psda_pkg::OP_DATA_READ) &&
    (st.op != psda_pkg::OP_DATA_WRITE);
  assign done = st.done;
  assign read_data = st.data_rdata;
  assign pc = st.pc;
  assign prog_rd = st.prog_rd;
  assign prog_wr = st.prog_wr;
  assign prog_cfg = st.prog_cfg;
  assign prog_addr = st.prog_addr;
  assign prog_wdata = st.prog_wdata;
  assign prog_wmask = st.prog_wmask;
  assign dspace_sel = st.dspace_sel;
  assign dspace_we = st.dspace_we;
  assign dspace_addr = ea_q;
  assign dspace_wdata = st.dspace_wdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  AST_TABLE_ADDR: assert property ( // [R1]
    accept && is_table && !is_twrite |=> prog_rd &&
      prog_addr == {$past(table_page_reg), $past(effective_address)})
    else $error("table read address is not page above effective address");

  AST_CFG_SELECT: assert property ( // [R2]
    accept && is_table |=> prog_cfg == $past(table_page_reg[psda_pkg::CFG_BIT]))
    else $error("configuration select does not follow table page top bit");

  AST_VIS_ADDR: assert property ( // [R3]
    accept && remap |=> prog_rd && !prog_cfg && prog_addr ==
      {1'h0, $past(visibility_page_reg), $past(effective_address[psda_pkg::VIS_LOW_W-1:0])})
    else $error("visibility address formed wrongly");

  AST_NO_REMAP: assert property ( // [R4]
    accept && req_op == psda_pkg::OP_DATA_READ && !vis_en |=> dspace_sel && !prog_rd)
    else $error("remap happened with visibility disabled");

  AST_MOVE_PENALTY: assert property ( // [R15]
    accept && remap && !rpt_active && is_move |=> !done ##1 !done ##1 done)
    else $error("move through visibility did not take one extra cycle");

  AST_OTHER_PENALTY: assert property ( // [R15]
    accept && remap && !rpt_active && !is_move |=> !done [*3] ##1 done)
    else $error("visibility access did not take two extra cycles");

  AST_RPT_MID: assert property ( // [R16]
    accept && remap && rpt_active && !rpt_edge |=> !done ##1 done)
    else $error("middle repeat iteration was penalised");

  AST_PHANTOM: assert property ( // [R10]
    $past(st.state) == psda_pkg::ST_ACCESS && $past(st.high_part) && done |->
      read_data[psda_pkg::DATA_W-1:psda_pkg::BYTE_W] == 8'h00)
    else $error("high table read returned nonzero phantom byte");

  AST_TWRITE_TWO: assert property ( // [R19]
    accept && is_twrite |=> prog_wr && table_busy ##1 done && !prog_wr)
    else $error("table write did not complete in two cycles");

  AST_LOW_LANES: assert property ( // [R12]
    prog_wr && st.op == psda_pkg::OP_TABLE_WRITE_LOW |-> prog_wmask[2] == 1'h0)
    else $error("low table write reached the top byte");

  AST_PC_STEP: assert property ( // [R7]
    pc_advance |=> pc == $past(pc) + psda_pkg::PC_STEP)
    else $error("program counter did not advance by two");

endmodule // psda_top
`default_nettype wire

// ### dv/psda_mem_model.sv
// Program memory and data space model facing the memory ports of the block.
`timescale 1ns/1ps
`default_nettype none
module psda_mem_model (
  // Program memory
  input wire logic prog_rd,
  input wire logic [23:0] prog_addr,
  output logic [23:0] prog_rdata,
  // Data space
  input wire logic dspace_sel,
  input wire logic [15:0] dspace_addr,
  output logic [15:0] dspace_rdata
);
  // Contents are a fixed function of the address, so every address bit shows in the data.
  function automatic logic [23:0] word(input logic [23:0] a);
    return {a[7:0] ^ a[23:16] ^ 8'h3C, a[15:0] ^ {a[23:16], 8'hA5}};
  endfunction

  function automatic logic [15:0] dword(input logic [15:0] a);
    return a ^ 16'h0F0F;
  endfunction

  // Outside a selected cycle the lines show the inverse, so a late sample cannot match.
  assign prog_rdata = prog_rd ? word(prog_addr) : ~word(prog_addr);
  assign dspace_rdata = dspace_sel ? dword(dspace_addr) : ~dword(dspace_addr);
endmodule // psda_mem_model
`default_nettype wire

// ### dv/psda_top_tb.sv
// Self-checking testbench of the program space data access block.
`timescale 1ns/1ps
`default_nettype none
module psda_top_tb;
  // ----------------------------------------------------------------
  // Stimulus, observed signals and capture
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  psda_pkg::psda_op_e req_op = psda_pkg::OP_DATA_READ;
  logic byte_mode = 1'b0;
  logic [15:0] ea = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic is_move = 1'b0;
  logic [4:0] rpt = 5'h00;
  logic [7:0] tpage = 8'h00;
  logic [7:0] vpage = 8'h00;
  logic [15:0] ccr = 16'h0000;
  logic pc_advance = 1'b0;
  wire logic req_ready, done, table_busy, prog_rd, prog_wr, prog_cfg, dspace_sel, dspace_we;
  wire logic [15:0] read_data, dspace_addr, dspace_wdata, dspace_rdata;
  wire logic [23:0] pc, prog_addr, prog_wdata, prog_rdata;
  wire logic [2:0] prog_wmask;
  int n_fail = 0;
  int cmp_count = 0;
  int lat;
  logic [23:0] c_addr, c_wdata, c_bits;
  logic [15:0] c_daddr, c_dwdata;
  logic [2:0] c_mask;
  logic c_cfg;

  always #2.5 clk = ~clk;

  psda_top DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .byte_mode(byte_mode), .effective_address(ea), .write_data(wd),
    .is_move(is_move), .rpt_active(rpt[4]), .rpt_first(rpt[3]), .rpt_last(rpt[2]),
    .rpt_irq_exit(rpt[1]), .rpt_irq_reentry(rpt[0]), .table_page_reg(tpage),
    .visibility_page_reg(vpage), .core_control_reg(ccr), .done(done), .read_data(read_data),
    .table_busy(table_busy), .pc_advance(pc_advance), .pc(pc), .prog_rd(prog_rd),
    .prog_wr(prog_wr), .prog_cfg(prog_cfg), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_wmask(prog_wmask), .prog_rdata(prog_rdata), .dspace_sel(dspace_sel),
    .dspace_we(dspace_we), .dspace_addr(dspace_addr), .dspace_wdata(dspace_wdata),
    .dspace_rdata(dspace_rdata));

  psda_mem_model u_mem (.prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .dspace_sel(dspace_sel), .dspace_addr(dspace_addr), .dspace_rdata(dspace_rdata));

  // ----------------------------------------------------------------
  // Compare, request and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_lat(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: done after %0d cycles, expected %0d", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One request; captures the cycle after acceptance and returns in the done cycle.
  task automatic run(input psda_pkg::psda_op_e op, input logic bm, input logic [15:0] a,
      input logic [15:0] w);
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    byte_mode <= bm;
    ea <= a;
    wd <= w;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    lat = 1;
    c_addr = prog_addr;
    c_wdata = prog_wdata;
    c_mask = prog_wmask;
    c_cfg = prog_cfg;
    c_daddr = dspace_addr;
    c_dwdata = dspace_wdata;
    c_bits = {18'h0, table_busy, req_ready, prog_rd, prog_wr, dspace_sel, dspace_we};
    while (done !== 1'b1 && lat < 20) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    cmp_val({20'h0, req_ready, done, prog_rd, prog_wr}, 24'h000008);
    cmp_val(pc, 24'h000000);
  endtask

  task automatic t_pc();
    repeat (3) begin
      @(posedge clk);
      pc_advance <= 1'b1;
      @(posedge clk);
      pc_advance <= 1'b0;
    end
    @(posedge clk);
    #1;
    cmp_val(pc, 24'h000006);
  endtask

  task automatic t_table_read();
    logic [23:0] a, p, e, m;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      tpage <= i[3] ? 8'h9C : 8'h1D;
      run(psda_pkg::psda_op_e'(i[2] ? psda_pkg::OP_TABLE_READ_HIGH :
        psda_pkg::OP_TABLE_READ_LOW), i[1], {15'h25B7, i[0]}, 16'h0000);
      a = {tpage, ea};
      p = u_mem.word(a);
      m = i[1] ? 24'h0000FF : 24'h00FFFF;
      e = i[2] ? ((i[1] && i[0]) ? 24'h0 : {16'h0, p[23:16]}) :
        (!i[1] ? {8'h0, p[15:0]} : (i[0] ? {16'h0, p[15:8]} : {16'h0, p[7:0]}));
      cmp_lat(lat, 2);
      cmp_val(c_addr, a);
      cmp_val({23'h0, c_cfg}, {23'h0, tpage[7]});
      cmp_val(c_bits, 24'h000028);
      cmp_val({8'h00, read_data} & m, e);
    end
  endtask

  task automatic t_table_write();
    logic [2:0] em;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tpage <= 8'h42;
      run(psda_pkg::psda_op_e'(i[2] ? psda_pkg::OP_TABLE_WRITE_HIGH :
        psda_pkg::OP_TABLE_WRITE_LOW), i[1], {15'h1A3C, i[0]}, 16'h7E81);
      em = i[2] ? ((i[1] && i[0]) ? 3'h0 : 3'h4) : (i[1] ? (i[0] ? 3'h2 : 3'h1) : 3'h3);
      cmp_lat(lat, 2);
      cmp_val(c_bits, 24'h000024);
      cmp_val(c_addr, {8'h42, ea});
      cmp_val({21'h0, c_mask}, {21'h0, em});
      if (em != 3'h0) begin
        cmp_val(c_wdata, i[2] ? 24'h810000 : (i[1] ? 24'h008181 : 24'h007E81));
      end
    end
  endtask

  // Data-space read or write with visibility set up as given.
  task automatic acc(input logic [15:0] cc, input psda_pkg::psda_op_e op,
      input logic [15:0] a, input logic mv, input logic [4:0] rp, input int el,
      input logic vis, input logic [7:0] vp);
    logic [23:0] pa;
    pa = {1'b0, vp, a[14:0]};
    @(posedge clk);
    ccr <= cc;
    is_move <= mv;
    rpt <= rp;
    vpage <= vp;
    run(op, 1'b0, a, 16'h6D2B);
    cmp_lat(lat, el);
    if (vis) begin
      cmp_val(c_bits, 24'h000008);
      cmp_val(c_addr, pa);
      cmp_val({23'h0, c_cfg}, 24'h000000);
      cmp_val({8'h00, read_data}, u_mem.word(pa) & 24'h00FFFF);
    end else if (op == psda_pkg::OP_DATA_WRITE) begin
      cmp_val(c_bits, 24'h000003);
      cmp_val({8'h00, c_daddr}, {8'h00, a});
      cmp_val({8'h00, c_dwdata}, 24'h006D2B);
    end else begin
      cmp_val(c_bits, 24'h000002);
      cmp_val({8'h00, c_daddr}, {8'h00, a});
      cmp_val({8'h00, read_data}, {8'h00, u_mem.dword(a)});
    end
  endtask

  task automatic t_vis();
    acc(16'h0004, psda_pkg::OP_DATA_READ, 16'hF2C4, 1'b1, 5'h00, 3, 1'b1, 8'hA3);
    acc(16'h0004, psda_pkg::OP_DATA_READ, 16'h8000, 1'b0, 5'h00, 4, 1'b1, 8'h52);
    acc(16'h0004, psda_pkg::OP_DATA_READ, 16'hFFFF, 1'b0, 5'h00, 4, 1'b1, 8'hFF);
  endtask

  task automatic t_repeat();
    logic [4:0] rp [5] = '{5'h18, 5'h14, 5'h12, 5'h11, 5'h10};
    for (int i = 0; i < 5; i++) begin
      acc(16'h0004, psda_pkg::OP_DATA_READ, 16'hC35A, 1'b1, rp[i], (i < 4) ? 4 : 2, 1'b1,
        8'h6B);
    end
  endtask

  task automatic t_data();
    acc(16'h0000, psda_pkg::OP_DATA_READ, 16'h9ABC, 1'b0, 5'h00, 2, 1'b0, 8'hA3);
    acc(16'hFFFB, psda_pkg::OP_DATA_READ, 16'hF000, 1'b0, 5'h00, 2, 1'b0, 8'hA3);
    acc(16'h0004, psda_pkg::OP_DATA_READ, 16'h7FFF, 1'b0, 5'h00, 2, 1'b0, 8'hA3);
    acc(16'h0004, psda_pkg::OP_DATA_WRITE, 16'hB004, 1'b0, 5'h00, 2, 1'b0, 8'hA3);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_pc();
    t_table_read();
    t_table_write();
    t_vis();
    t_repeat();
    t_data();
    finish_test();
  end

  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule // psda_top_tb
`default_nettype wire
